// File: sim/pcr_host.sv
// Serial-interface engine model that issues register write and read strobes.
module pcr_host (
  input wire logic ref_clk,
  output logic wr_en,
  output logic rd_en,
  output pcr_pkg::pcr_byte_t addr,
  output pcr_pkg::pcr_byte_t wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import pcr_pkg::*;

  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end

  // A random idle gap lets the host answer promptly or slowly.
  // Released address and data lines flip so stale values are never mistaken for live ones.
  task automatic xfer(input logic w, input pcr_byte_t a, input pcr_byte_t d);
    repeat ($urandom_range(2)) @(posedge ref_clk);
    @(posedge ref_clk);
    wr_en <= w;
    rd_en <= ~w;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : xfer
endmodule : pcr_host

// File: sim/tb.sv
// Self-checking bench for the converter control register bank.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pcr_pkg::*;
  logic ref_clk, rst, h_wr, h_rd, strap, ripple, from_strap, dvt, rd_seen;
  pcr_byte_t h_addr, h_wdata, reg_rdata, v;
  logic [3:0] pin_en, ev;
  logic [4:0] supply_on;
  logic [1:0] ph_core, ph_sys, ph_mem;
  logic [2:0] ffreq, dis;
  pcr_slew_t slew;
  pcr_code_t code;
  int err_count, total_checks;
  time t0;
  pcr_byte_t exp_q[$];

  pcr_host u_host (.ref_clk(ref_clk), .wr_en(h_wr), .rd_en(h_rd), .addr(h_addr),
    .wdata(h_wdata));

  // A short ramp step still leaves every slew code below 7 at one cycle per step or more; code 6 steps every cycle.
  pcr_top #(.STEP_SLOW_CYCLES(64)) DUT (.ref_clk(ref_clk), .rst(rst), .reg_wr_en(h_wr),
    .reg_rd_en(h_rd), .reg_addr(h_addr), .reg_wdata(h_wdata), .reg_rdata(reg_rdata),
    .core_buck_enable_pin(pin_en[3]), .system_buck_enable_pin(pin_en[2]),
    .memory_buck_enable_pin(pin_en[1]), .linear_reg_enable_pin(pin_en[0]),
    .undervoltage_lockout(ev[0]), .warm_reset_pin_n(~ev[1]), .power_on_reset_output(ev[2]),
    .clock_backup_supply_low(ev[3]), .core_voltage_strap_pin(strap),
    .slew_rate_register(slew), .supply_on(supply_on), .core_buck_phase(ph_core),
    .system_buck_phase(ph_sys), .memory_buck_phase(ph_mem), .low_ripple(ripple),
    .forced_fixed_freq(ffreq), .discharge_active(dis), .core_target_code(code),
    .core_from_strap(from_strap), .dynamic_voltage_transition(dvt));

  always #2 ref_clk = ~ref_clk;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input pcr_byte_t a, input pcr_byte_t d);
    u_host.xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input pcr_byte_t a, input pcr_byte_t e);
    exp_q.push_back(e);
    u_host.xfer(1'b0, a, 8'h00);
  endtask : rd

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_cyc

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  // Read data is registered, so it is compared on the falling edge after the strobe was taken.
  always @(posedge ref_clk) rd_seen <= h_rd;
  always @(negedge ref_clk) begin
    if (rd_seen) chk(reg_rdata, exp_q.pop_front());
  end

  initial begin
    #100000;
    err_count++;
    conclude();
  end

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    pin_en = 4'hF;
    ev = 4'h0;
    strap = 1'b0;
    slew = 3'h7;
    rd_seen = 1'b0;
    err_count = 0;
    total_checks = 0;
    void'($urandom(17));
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    wait_cyc(10);
    rd(8'h03, 8'hFF);
    rd(8'h04, 8'hB1);
    rd(8'h05, 8'h40);
    rd(8'h06, 8'h14);
    rd(8'h07, 8'h00);
    chk({ph_sys, ph_mem, ripple, ffreq}, 8'hB1);
    chk({3'h0, code}, 8'h14);
    chk({7'h0, from_strap}, 8'h01);
    $display("test reset_values done");
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom);
      wr(8'h04, v);
      rd(8'h04, v);
      wait_cyc(3);
      chk({ph_sys, ph_mem, ripple, ffreq}, v);
      chk({6'h0, ph_core}, 8'h00);
    end
    wr(8'h06, 8'hFF);
    rd(8'h06, 8'h1F);
    wr(8'h05, 8'h3F);
    rd(8'h05, 8'h07);
    $display("test mode_fields done");
    wr(8'h06, 8'h0A);
    wr(8'h05, 8'h00);
    wait_cyc(3);
    chk({7'h0, dvt}, 8'h00);
    chk({3'h0, code}, 8'h14);
    wr(8'h05, 8'h80);
    @(negedge ref_clk);
    chk({7'h0, dvt}, 8'h01);
    wait_cyc(3);
    chk({3'h0, code}, 8'h0A);
    chk({7'h0, dvt | from_strap}, 8'h00);
    @(posedge ref_clk);
    slew <= 3'h4;
    wr(8'h06, 8'h1A);
    wr(8'h05, 8'h80);
    t0 = $time;
    wr(8'h05, 8'h00);
    wait_cyc(1);
    chk({7'h0, dvt}, 8'h01);
    for (int n = 0; n < 1000 && dvt; n++) begin
      @(posedge ref_clk);
      #1;
    end
    v = 8'(($time - t0) / 4);
    chk({7'h0, v >= 60 && v <= 72}, 8'h01);
    chk({3'h0, code}, 8'h1A);
    $display("test voltage_ramp done");
    wr(8'h05, 8'h07);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr(8'h03, v);
      wait_cyc(6);
      chk({3'h0, supply_on}, {3'h0, v[5:1]});
      chk({5'h0, dis}, {5'h0, ~v[4], ~v[5], ~v[3]});
      rd(8'h03, {2'b11, v[5:1], 1'b1});
    end
    @(posedge ref_clk);
    pin_en <= 4'hE;
    wait_cyc(8);
    chk({3'h0, supply_on}, {3'h0, v[5:3], 2'b00});
    wr(8'h03, 8'h00);
    rd(8'h03, 8'hC7);
    @(posedge ref_clk);
    pin_en <= 4'hF;
    wait_cyc(8);
    chk({3'h0, supply_on}, 8'h03);
    $display("test enable_gate done");
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      strap <= i[0];
      wr(8'h03, 8'h00);
      wr(8'h04, 8'h00);
      wr(8'h05, 8'h07);
      wr(8'h06, 8'h0A);
      wait_cyc(6);
      chk({dis, supply_on}, 8'hE0);
      @(posedge ref_clk);
      ev <= 4'(1 << i);
      wait_cyc(8);
      @(posedge ref_clk);
      ev <= 4'h0;
      wait_cyc(10);
      rd(8'h03, i == 0 ? 8'hFF : 8'hC1);
      rd(8'h04, i == 0 ? 8'hB1 : 8'h00);
      rd(8'h05, i == 0 ? 8'h40 : 8'h47);
      rd(8'h06, i == 3 ? 8'h0A : (i[0] ? 8'h1E : 8'h14));
      chk({7'h0, from_strap}, 8'h01);
    end
    $display("test reset_events done");
    wait_cyc(4);
    conclude();
  end
endmodule : tb

// File: src/pcr_map.svh
// Offsets, field positions, reset values and timing counts of the converter control registers.
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH

`define PCR_ADDR_W 8
`define PCR_ADDR_GATE 8'h03
`define PCR_ADDR_CONV 8'h04
`define PCR_ADDR_CHG 8'h05
`define PCR_ADDR_CODE 8'h06

`define PCR_GATE_MSB 5
`define PCR_GATE_LSB 1
`define PCR_GATE_RST 5'h1F
`define PCR_GATE_FILL 8'hFF

`define PCR_CONV_RST 8'hB1
`define PCR_CONV_SYS_PH_MSB 7
`define PCR_CONV_SYS_PH_LSB 6
`define PCR_CONV_MEM_PH_MSB 5
`define PCR_CONV_MEM_PH_LSB 4
`define PCR_CONV_RIPPLE_BIT 3
`define PCR_CONV_FF_SYS_BIT 2
`define PCR_CONV_FF_CORE_BIT 1
`define PCR_CONV_FF_MEM_BIT 0

`define PCR_CHG_GO_BIT 7
`define PCR_CHG_ADJ_BIT 6
`define PCR_CHG_DIS_MSB 2
`define PCR_CHG_DIS_LSB 0
`define PCR_CHG_RST 8'h40
`define PCR_CHG_ADJ_RST 1'b1
`define PCR_CHG_DIS_RST 3'h0

`define PCR_CODE_MSB 4
`define PCR_CODE_RST 5'h14
`define PCR_CODE_MSB_RST 1'b1
`define PCR_CODE_LO_GND 4'h4
`define PCR_CODE_LO_VCC 4'hE

`define PCR_SLEW_IMMEDIATE 3'h7
`define PCR_STEP_UV 25000
`define PCR_SLEW0_UV_PER_US 225
`define PCR_CLK_PERIOD_NS 4
`define PCR_STEP_SLOW_NS (`PCR_STEP_UV * 1000 / `PCR_SLEW0_UV_PER_US)
`define PCR_STEP_SLOW_CYCLES (`PCR_STEP_SLOW_NS / `PCR_CLK_PERIOD_NS)
`define PCR_BOOT_CYCLES 3'h5

`endif

// File: src/pcr_pkg.sv
// Types shared by the converter control register block.
package pcr_pkg;
  typedef logic [7:0] pcr_byte_t;
  typedef logic [4:0] pcr_code_t;
  typedef logic [2:0] pcr_slew_t;
  typedef logic [14:0] pcr_count_t;
  typedef enum logic [1:0] {
    PCR_RAMP_IDLE = 2'b01,
    PCR_RAMP_RUN = 2'b10
  } pcr_ramp_e;
endpackage : pcr_pkg

// File: src/pcr_ramp.sv
// Core voltage code ramp that steps the internal target toward a requested code.
`include "pcr_map.svh"
module pcr_ramp #(
  parameter int unsigned STEP_SLOW_CYCLES = `PCR_STEP_SLOW_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic load,
  input wire pcr_pkg::pcr_code_t load_code,
  input wire logic start,
  input wire pcr_pkg::pcr_code_t target,
  input wire pcr_pkg::pcr_slew_t slew,
  output pcr_pkg::pcr_code_t cur_code,
  output logic busy,
  output logic done
);
  import pcr_pkg::*;

  pcr_ramp_e state_q;
  pcr_code_t tgt_q;
  pcr_count_t cnt_q;
  pcr_count_t period;

  // Each faster slew code halves the time between 25 mV steps.
  assign period = pcr_count_t'(STEP_SLOW_CYCLES >> slew);
  assign busy = (state_q == PCR_RAMP_RUN);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= PCR_RAMP_IDLE;
      cur_code <= `PCR_CODE_RST;
      tgt_q <= `PCR_CODE_RST;
      cnt_q <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        // A default reload aborts a ramp; reporting done lets the trigger bit drop.
        cur_code <= load_code;
        tgt_q <= load_code;
        done <= busy;
        state_q <= PCR_RAMP_IDLE;
      end else if (start) begin
        tgt_q <= target;
        cnt_q <= '0;
        if (slew == `PCR_SLEW_IMMEDIATE) begin
          cur_code <= target;
          done <= 1'b1;
          state_q <= PCR_RAMP_IDLE;
        end else begin
          state_q <= PCR_RAMP_RUN;
        end
      end else begin
        unique case (state_q)
          PCR_RAMP_IDLE: begin
            cnt_q <= '0;
          end
          PCR_RAMP_RUN: begin
            // Completion is the code match, not the analog output settling.
            if (cur_code == tgt_q) begin
              done <= 1'b1;
              state_q <= PCR_RAMP_IDLE;
            end else if (cnt_q >= period - 15'h0001) begin
              cnt_q <= '0;
              cur_code <= (cur_code < tgt_q) ? cur_code + 5'h01 : cur_code - 5'h01;
            end else begin
              cnt_q <= cnt_q + 15'h0001;
            end
          end
          default: begin
            state_q <= PCR_RAMP_IDLE;
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_RAMP_IMMEDIATE: assert property (
    !load && start && slew == `PCR_SLEW_IMMEDIATE |=> done && cur_code == $past(target)
  ) else $error("Immediate slew did not jump to the target code.");

  AST_RAMP_MATCH_DONE: assert property (
    busy && cur_code == tgt_q && !load && !start |=> done && !busy
  ) else $error("Ramp did not finish on reaching the requested code.");

  AST_RAMP_STEP_SPACING: assert property (
    busy && !load && !start && cur_code != tgt_q && cnt_q < period - 15'h0001
    |=> $stable(cur_code)
  ) else $error("Ramp stepped before its slew period elapsed.");
endmodule : pcr_ramp

// File: src/pcr_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
module pcr_sync #(
  parameter int WIDTH = 9,
  parameter logic [8:0] RESET_VAL = 9'h000
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_stable
);
  import pcr_pkg::*;

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          s1_q[gi] <= RESET_VAL[gi];
          s2_q[gi] <= RESET_VAL[gi];
          s3_q[gi] <= RESET_VAL[gi];
          pin_stable[gi] <= RESET_VAL[gi];
        end else begin
          s1_q[gi] <= pin_async[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            pin_stable[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate
endmodule : pcr_sync

// File: src/pcr_top.sv
// Converter enable, mode, discharge and core voltage control register bank.
// Operation
// - Supply on only when bit and pin high.
// - Lockout sets enable bits; host writes both.
// - Low enable pin forces its bit to 1.
// - Phase codes delay second and third converters.
// - Core converter phase fixed at zero.
// - Bit 3 picks efficiency or low ripple.
// - Bits 2,1,0 force fixed-frequency switching.
// - Lockout reloads converter-control default B1h.
// - Trigger write ramps core to code register.
// - Trigger self-clears when done; zero ignored.
// - Done when internal code reaches request.
// - Source bit picks register or strap pin.
// - Four reset events restore source bit.
// - Discharge bits discharge disabled converter outputs.
// - Second control register resets to 40h.
// - Five-bit code, 25 mV steps, top 1.6 V.
// - Three reset events reload code from strap; backup-supply low does not.
// - Slew code sets ramp rate; 111 immediate.
`include "pcr_map.svh"
module pcr_top #(
  parameter int unsigned STEP_SLOW_CYCLES = `PCR_STEP_SLOW_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire pcr_pkg::pcr_byte_t reg_addr,
  input wire pcr_pkg::pcr_byte_t reg_wdata,
  output pcr_pkg::pcr_byte_t reg_rdata,
  input wire logic core_buck_enable_pin,
  input wire logic system_buck_enable_pin,
  input wire logic memory_buck_enable_pin,
  input wire logic linear_reg_enable_pin,
  input wire logic undervoltage_lockout,
  input wire logic warm_reset_pin_n,
  input wire logic power_on_reset_output,
  input wire logic clock_backup_supply_low,
  input wire logic core_voltage_strap_pin,
  input wire pcr_pkg::pcr_slew_t slew_rate_register,
  output logic [4:0] supply_on,
  output logic [1:0] core_buck_phase,
  output logic [1:0] system_buck_phase,
  output logic [1:0] memory_buck_phase,
  output logic low_ripple,
  output logic [2:0] forced_fixed_freq,
  output logic [2:0] discharge_active,
  output pcr_pkg::pcr_code_t core_target_code,
  output logic core_from_strap,
  output logic dynamic_voltage_transition
);
  import pcr_pkg::*;

  // Synchronised pins, index 8 down to 0.
  logic [8:0] pins_raw;
  logic [8:0] pins_s;
  logic [4:0] enable_s;
  logic undervoltage_lockout_s;
  logic warm_n_s;
  logic por_s;
  logic backup_low_s;
  logic strap_s;

  logic [2:0] boot_cnt_q;
  logic boot_load;
  logic undervoltage_lockout_ev;
  logic code_ev;
  logic adj_ev;

  logic [`PCR_GATE_MSB:`PCR_GATE_LSB] gate_q;
  pcr_byte_t conv_q;
  logic go_q;
  logic adj_q;
  logic [`PCR_CHG_DIS_MSB:`PCR_CHG_DIS_LSB] dis_q;
  pcr_code_t code_q;
  pcr_code_t code_dflt;

  logic wr_gate;
  logic wr_conv;
  logic wr_chg;
  logic wr_code;
  logic go_start;
  logic ramp_done;
  logic ramp_busy;

  // One decoder serves both the write strobes and the read mux.
  function automatic logic reg_hit(input pcr_byte_t addr, input pcr_byte_t slot);
    reg_hit = (addr == slot);
  endfunction : reg_hit

  assign pins_raw = {core_buck_enable_pin, system_buck_enable_pin, memory_buck_enable_pin,
                     linear_reg_enable_pin, undervoltage_lockout, warm_reset_pin_n,
                     power_on_reset_output, clock_backup_supply_low, core_voltage_strap_pin};

  // Warm reset idles high so that the first cycles after release show no event.
  pcr_sync #(
    .WIDTH(9),
    .RESET_VAL(9'h008)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_async(pins_raw),
    .pin_stable(pins_s)
  );

  // Both linear regulator bits follow the one shared regulator pin.
  assign enable_s = {pins_s[8], pins_s[7], pins_s[6], pins_s[5], pins_s[5]};
  assign undervoltage_lockout_s = pins_s[4];
  assign warm_n_s = pins_s[3];
  assign por_s = pins_s[2];
  assign backup_low_s = pins_s[1];
  assign strap_s = pins_s[0];

  // The strap is only trusted after the synchroniser has filled, so the boot
  // reload waits a few cycles past reset release instead of using the raw pin.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      boot_cnt_q <= 3'h0;
    end else if (boot_cnt_q != `PCR_BOOT_CYCLES) begin
      boot_cnt_q <= boot_cnt_q + 3'h1;
    end
  end

  assign boot_load = (boot_cnt_q == `PCR_BOOT_CYCLES - 3'h1);
  assign undervoltage_lockout_ev = undervoltage_lockout_s | boot_load;
  assign code_ev = undervoltage_lockout_ev | ~warm_n_s | por_s;
  assign adj_ev = code_ev | backup_low_s;
  assign code_dflt = {`PCR_CODE_MSB_RST, strap_s ? `PCR_CODE_LO_VCC : `PCR_CODE_LO_GND};

  assign wr_gate = reg_wr_en && reg_hit(reg_addr, `PCR_ADDR_GATE);
  assign wr_conv = reg_wr_en && reg_hit(reg_addr, `PCR_ADDR_CONV);
  assign wr_chg = reg_wr_en && reg_hit(reg_addr, `PCR_ADDR_CHG);
  assign wr_code = reg_wr_en && reg_hit(reg_addr, `PCR_ADDR_CODE);
  assign go_start = wr_chg && reg_wdata[`PCR_CHG_GO_BIT];

  // Supply enable gate: a low pin holds its bit at one over any host write.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gate_q <= `PCR_GATE_RST;
    end else if (undervoltage_lockout_ev) begin
      gate_q <= `PCR_GATE_RST;
    end else begin
      gate_q <= (wr_gate ? reg_wdata[`PCR_GATE_MSB:`PCR_GATE_LSB] : gate_q) | ~enable_s;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      supply_on <= 5'h00;
    end else begin
      supply_on <= gate_q & enable_s;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      conv_q <= `PCR_CONV_RST;
    end else if (undervoltage_lockout_ev) begin
      conv_q <= `PCR_CONV_RST;
    end else if (wr_conv) begin
      conv_q <= reg_wdata;
    end
  end

  assign core_buck_phase = 2'h0;
  assign system_buck_phase = conv_q[`PCR_CONV_SYS_PH_MSB:`PCR_CONV_SYS_PH_LSB];
  assign memory_buck_phase = conv_q[`PCR_CONV_MEM_PH_MSB:`PCR_CONV_MEM_PH_LSB];
  assign low_ripple = conv_q[`PCR_CONV_RIPPLE_BIT];
  assign forced_fixed_freq = {conv_q[`PCR_CONV_FF_SYS_BIT], conv_q[`PCR_CONV_FF_CORE_BIT],
                              conv_q[`PCR_CONV_FF_MEM_BIT]};

  // Trigger bit: a host set in the done cycle wins, and writing zero is ignored.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      go_q <= 1'b0;
    end else if (undervoltage_lockout_ev) begin
      go_q <= 1'b0;
    end else if (go_start && !code_ev) begin
      // A code reload swallows the start, so a set here would never see done.
      go_q <= 1'b1;
    end else if (ramp_done) begin
      go_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      adj_q <= `PCR_CHG_ADJ_RST;
    end else if (adj_ev) begin
      adj_q <= `PCR_CHG_ADJ_RST;
    end else if (wr_chg) begin
      adj_q <= reg_wdata[`PCR_CHG_ADJ_BIT];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dis_q <= `PCR_CHG_DIS_RST;
    end else if (undervoltage_lockout_ev) begin
      dis_q <= `PCR_CHG_DIS_RST;
    end else if (wr_chg) begin
      dis_q <= reg_wdata[`PCR_CHG_DIS_MSB:`PCR_CHG_DIS_LSB];
    end
  end

  // Discharge order is system, core, memory to match the bit layout.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      discharge_active <= 3'h0;
    end else begin
      discharge_active <= dis_q & ~{supply_on[3], supply_on[4], supply_on[2]};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      code_q <= `PCR_CODE_RST;
    end else if (code_ev) begin
      code_q <= code_dflt;
    end else if (wr_code) begin
      code_q <= reg_wdata[`PCR_CODE_MSB:0];
    end
  end

  pcr_ramp #(
    .STEP_SLOW_CYCLES(STEP_SLOW_CYCLES)
  ) u_ramp (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(code_ev),
    .load_code(code_dflt),
    .start(go_start),
    .target(code_q),
    .slew(slew_rate_register),
    .cur_code(core_target_code),
    .busy(ramp_busy),
    .done(ramp_done)
  );

  assign core_from_strap = adj_q;
  assign dynamic_voltage_transition = go_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
      if (reg_hit(reg_addr, `PCR_ADDR_GATE)) begin
        reg_rdata <= `PCR_GATE_FILL & {2'h3, gate_q, 1'h1};
      end else if (reg_hit(reg_addr, `PCR_ADDR_CONV)) begin
        reg_rdata <= conv_q;
      end else if (reg_hit(reg_addr, `PCR_ADDR_CHG)) begin
        reg_rdata <= {go_q, adj_q, 3'h0, dis_q};
      end else if (reg_hit(reg_addr, `PCR_ADDR_CODE)) begin
        reg_rdata <= {3'h0, code_q};
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_quiet;
    !undervoltage_lockout_ev && !code_ev;
  endsequence

  sequence s_write(logic [7:0] slot);
    reg_wr_en && reg_addr == slot;
  endsequence

  AST_SUPPLY_AND: assert property (
    ##1 supply_on == $past(gate_q & enable_s)
  ) else $error("Supply state is not the AND of bit and pin.");

  AST_UNDERVOLTAGE_LOCKOUT_ENABLES: assert property (
    undervoltage_lockout_s |=> gate_q == `PCR_GATE_RST
  ) else $error("Lockout did not set every enable bit.");

  AST_PIN_LOW_FORCES: assert property (
    ##1 (~$past(enable_s) & ~gate_q) == 5'h00
  ) else $error("Enable bit not held at one while its pin is low.");

  AST_PHASE_WRITE: assert property (
    s_quiet ##0 s_write(`PCR_ADDR_CONV) |=> system_buck_phase == $past(reg_wdata[7:6])
      && memory_buck_phase == $past(reg_wdata[5:4])
  ) else $error("Phase outputs do not follow the written codes.");

  AST_CORE_PHASE_ZERO: assert property (
    core_buck_phase == 2'h0
  ) else $error("Core converter phase is not zero.");

  AST_UNDERVOLTAGE_LOCKOUT_CONV: assert property (
    undervoltage_lockout_ev |=> conv_q == `PCR_CONV_RST && forced_fixed_freq == 3'h1 && !low_ripple
  ) else $error("Lockout did not restore converter control default.");

  AST_GO_SETS: assert property (
    s_quiet ##0 go_start |=> dynamic_voltage_transition && (ramp_busy || ramp_done)
  ) else $error("Trigger write did not start a transition.");

  AST_GO_CLEARS: assert property (
    ramp_done && !go_start && !undervoltage_lockout_ev |=> !go_q
  ) else $error("Trigger bit not cleared after transition.");

  AST_GO_ZERO_IGNORED: assert property (
    go_q && wr_chg && !reg_wdata[7] && !ramp_done && !undervoltage_lockout_ev |=> go_q
  ) else $error("Writing zero changed the trigger bit.");

  AST_ADJ_EVENTS: assert property (
    adj_ev |=> core_from_strap
  ) else $error("Reset event did not restore the source bit.");

  AST_DISCHARGE: assert property (
    ##2 discharge_active[1] == ($past(dis_q[1], 1) && !$past(supply_on[4], 1))
  ) else $error("Core discharge not tied to bit and disabled state.");

  AST_CODE_DEFAULT: assert property (
    code_ev |=> code_q == {1'b1, $past(strap_s) ? 4'hE : 4'h4}
  ) else $error("Code default not loaded from strap.");

  AST_UPPER_ZERO: assert property (
    reg_rd_en && reg_addr == `PCR_ADDR_CODE |=> reg_rdata[7:5] == 3'h0
  ) else $error("Unused code bits did not read zero.");
endmodule : pcr_top
